// ===== gcd_pkg.sv
// Package for the global configuration and diagnostic routing block.
// Assumes a single 100 MHz clock and a synchronous, active-high reset.
package gcd_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  GLOBAL_CONFIGURATION_ADDR = 8'h00;
    localparam logic [7:0]  WRITE_ADDR_OFFSET         = 8'h80;
    localparam int          CONFIG_WIDTH              = 17;
    localparam logic [16:0] CONFIG_RESET              = 17'h0_0000;
    localparam logic [31:0] READ_ZERO                 = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CURRENT_REF_ANALOG_BIT           = 0;
    localparam int INTERNAL_SENSE_BIT               = 1;
    localparam int QUIET_PWM_BIT                    = 2;
    localparam int ENCODER_COMMUTATION_BIT          = 3;
    localparam int INVERT_DIRECTION_BIT             = 4;
    localparam int FIRST_DIAG_ON_DRIVER_ERROR_BIT   = 5;
    localparam int FIRST_DIAG_ON_PREWARNING_BIT     = 6;
    localparam int FIRST_DIAG_ON_STALL_BIT          = 7;
    localparam int FIRST_DIAG_AS_STEP_OUT_BIT       = 7;
    localparam int SECOND_DIAG_ON_STALL_BIT         = 8;
    localparam int SECOND_DIAG_AS_DIRECTION_OUT_BIT = 8;
    localparam int SECOND_DIAG_ON_TABLE_INDEX_BIT   = 9;
    localparam int SECOND_DIAG_ON_CHOPPER_ON_BIT    = 10;
    localparam int SECOND_DIAG_SKIP_TOGGLE_BIT      = 11;

    // Number of event sources per diagnostic pin in controller mode
    localparam int FIRST_DIAG_SOURCES  = 3;
    localparam int SECOND_DIAG_SOURCES = 4;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic overTemperature;
        logic shortToGround;
        logic chargePumpUndervoltage;
        logic overTempPrewarning;
        logic motorStall;
        logic tableIndexZero;
        logic chopperOnSecondHalf;
        logic lostStepIncrement;
    } gcd_event_type;

    typedef struct packed {
        logic interruptLevel;
        logic positionCompare;
        logic stepPulse;
        logic commandedDirection;
    } gcd_motion_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [31:0] wdata;
    } gcd_access_type;

endpackage : gcd_pkg

// ===== gcd_event_merge.sv
// Merges enabled event sources onto one diagnostic line.
// Assumes event levels are synchronous to the block clock.
`timescale 1ns/1ps

module gcd_event_merge #(
    parameter int N = 2
) (
    input  wire logic [N-1:0] enables,
    input  wire logic [N-1:0] events,
    output wire logic         active
);

    assign active = |(enables & events);

endmodule : gcd_event_merge

// ===== gcd_global_config.sv
// Global configuration register and diagnostic pin routing.
// Assumes the serial interface delivers decoded accesses synchronous to clk.
//
// How it works
// - Bit 0 picks analog input as current reference, else internal voltage.
// - Bit 1 selects internal sense resistors referenced by analog input current.
// - Bit 2 enables quiet voltage PWM; host turns it on only at standstill.
// - Bit 3 enables full-step encoder commutation; host leaves it zero.
// - Bit 4 inverts motor direction relative to commanded direction.
// - Controller mode bit 5 drives first pin on driver errors.
// - First diagnostic pin is driven active low throughout reset.
// - Controller mode bit 6 drives first pin on overtemperature prewarning.
// - Controller mode bit 7 drives first pin on stall; threshold programmed first.
// - Step/dir mode bit 7 selects interrupt or dual-edge step output.
// - Controller mode bit 8 drives second pin on stall; threshold first.
// - Step/dir mode bit 8 selects position compare or direction output.
// - Controller mode bit 9 drives second pin at table index zero.
// - Controller mode bit 10 drives second pin while chopper on.
// - Controller mode bit 11 toggles second pin per skipped step.
// - The register resets to zero.
`timescale 1ns/1ps

module gcd_global_config (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire gcd_pkg::gcd_access_type access,
    input  wire logic                    stepDirModeSelectPin,
    input  wire gcd_pkg::gcd_event_type  driverEvents,
    input  wire gcd_pkg::gcd_motion_type motion,
    output logic [31:0]                  readData_q,
    output logic                         readValid_q,
    output logic                         currentRefAnalog_q,
    output logic                         internalSense_q,
    output logic                         quietPwmEnable_q,
    output logic                         encoderCommutation_q,
    output logic                         motorDirection_q,
    output logic                         firstDiagPinN_q,
    output logic                         secondDiagPinN_q
);

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    logic [gcd_pkg::CONFIG_WIDTH-1:0] config_q;
    logic [gcd_pkg::CONFIG_WIDTH-1:0] config_d;
    logic [31:0]                      readData_d;
    logic                             readValid_d;
    logic                             skipToggle_q;
    logic                             stepToggle_q;

    wire writeHit = access.valid && (access.addr ==
        (gcd_pkg::GLOBAL_CONFIGURATION_ADDR | gcd_pkg::WRITE_ADDR_OFFSET));
    wire readHit  = access.valid && (access.addr == gcd_pkg::GLOBAL_CONFIGURATION_ADDR);
    wire isWrite  = |(access.addr & gcd_pkg::WRITE_ADDR_OFFSET);
    wire isRead   = access.valid && !isWrite;

    assign config_d = writeHit ? access.wdata[gcd_pkg::CONFIG_WIDTH-1:0] : config_q;

    // Unmapped reads answer zero rather than stale data
    assign readData_d  = readHit ? 32'(config_q) : gcd_pkg::READ_ZERO;
    assign readValid_d = isRead;

    always_ff @(posedge clk) begin
        if (reset) begin
            config_q <= gcd_pkg::CONFIG_RESET;
        end else begin
            config_q <= config_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            readData_q <= gcd_pkg::READ_ZERO;
        end else begin
            readData_q <= readData_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            readValid_q <= 1'b0;
        end else begin
            readValid_q <= readValid_d;
        end
    end

    // ----------------------------------------------------------------
    // Static configuration outputs
    // ----------------------------------------------------------------
    // Bits 2 and 3 pass as written; safe use is left to the host
    wire currentRefAnalog_d   = config_q[gcd_pkg::CURRENT_REF_ANALOG_BIT];
    wire internalSense_d      = config_q[gcd_pkg::INTERNAL_SENSE_BIT];
    wire quietPwmEnable_d     = config_q[gcd_pkg::QUIET_PWM_BIT];
    wire encoderCommutation_d = config_q[gcd_pkg::ENCODER_COMMUTATION_BIT];
    wire motorDirection_d     = motion.commandedDirection
                                ^ config_q[gcd_pkg::INVERT_DIRECTION_BIT];

    always_ff @(posedge clk) begin
        if (reset) begin
            currentRefAnalog_q <= 1'b0;
        end else begin
            currentRefAnalog_q <= currentRefAnalog_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            internalSense_q <= 1'b0;
        end else begin
            internalSense_q <= internalSense_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            quietPwmEnable_q <= 1'b0;
        end else begin
            quietPwmEnable_q <= quietPwmEnable_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            encoderCommutation_q <= 1'b0;
        end else begin
            encoderCommutation_q <= encoderCommutation_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            motorDirection_q <= 1'b0;
        end else begin
            motorDirection_q <= motorDirection_d;
        end
    end

    // ----------------------------------------------------------------
    // First diagnostic pin
    // ----------------------------------------------------------------
    wire driverError = driverEvents.overTemperature | driverEvents.shortToGround
                       | driverEvents.chargePumpUndervoltage;
    wire firstEnabledEvent;

    gcd_event_merge #(
        .N (gcd_pkg::FIRST_DIAG_SOURCES)
    ) firstMerge (
        .enables ({config_q[gcd_pkg::FIRST_DIAG_ON_DRIVER_ERROR_BIT],
                   config_q[gcd_pkg::FIRST_DIAG_ON_PREWARNING_BIT],
                   config_q[gcd_pkg::FIRST_DIAG_ON_STALL_BIT]}),
        .events  ({driverError,
                   driverEvents.overTempPrewarning,
                   driverEvents.motorStall}),
        .active  (firstEnabledEvent)
    );

    // Dual-edge step output: one pin edge per incoming step pulse
    wire stepToggle_d = stepToggle_q ^ motion.stepPulse;
    wire firstStepDirLevel = config_q[gcd_pkg::FIRST_DIAG_AS_STEP_OUT_BIT]
                             ? stepToggle_q : !motion.interruptLevel;
    wire firstPinN_d = stepDirModeSelectPin ? !firstEnabledEvent
                                            : firstStepDirLevel;

    // ----------------------------------------------------------------
    // Second diagnostic pin
    // ----------------------------------------------------------------
    wire secondEnabledEvent;

    gcd_event_merge #(
        .N (gcd_pkg::SECOND_DIAG_SOURCES)
    ) secondMerge (
        .enables ({config_q[gcd_pkg::SECOND_DIAG_ON_STALL_BIT],
                   config_q[gcd_pkg::SECOND_DIAG_ON_TABLE_INDEX_BIT],
                   config_q[gcd_pkg::SECOND_DIAG_ON_CHOPPER_ON_BIT],
                   config_q[gcd_pkg::SECOND_DIAG_SKIP_TOGGLE_BIT]}),
        .events  ({driverEvents.motorStall,
                   driverEvents.tableIndexZero,
                   driverEvents.chopperOnSecondHalf,
                   skipToggle_q}),
        .active  (secondEnabledEvent)
    );

    // Toggle only counts while the option is on; mixing it is the host's fault
    wire skipToggle_d = skipToggle_q ^ (driverEvents.lostStepIncrement
                        & config_q[gcd_pkg::SECOND_DIAG_SKIP_TOGGLE_BIT]);
    wire secondStepDirLevel = config_q[gcd_pkg::SECOND_DIAG_AS_DIRECTION_OUT_BIT]
                              ? motorDirection_q : !motion.positionCompare;
    wire secondPinN_d = stepDirModeSelectPin ? !secondEnabledEvent
                                             : secondStepDirLevel;

    // ----------------------------------------------------------------
    // Pin registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            firstDiagPinN_q <= 1'b0;
        end else begin
            firstDiagPinN_q <= firstPinN_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            secondDiagPinN_q <= 1'b1;
        end else begin
            secondDiagPinN_q <= secondPinN_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stepToggle_q <= 1'b0;
        end else begin
            stepToggle_q <= stepToggle_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            skipToggle_q <= 1'b0;
        end else begin
            skipToggle_q <= skipToggle_d;
        end
    end

endmodule : gcd_global_config

// ===== gcd_host_model.sv
// Host side model issuing decoded register accesses.
// Assumes clk is the block clock; drives just after the falling edge.
`timescale 1ns/1ps
module gcd_host_model (
    input  wire logic             clk,
    output gcd_pkg::gcd_access_type access
);
    initial access = '0;

    // Valid held across one rising edge only
    task automatic xfer(input logic [7:0] addr, input logic [31:0] data);
        @(negedge clk);
        access <= '{1'b1, addr, data};
        @(negedge clk);
        access.valid <= 1'b0;
    endtask : xfer

    // Skip toggle written alone: bits 10:8 cleared when bit 11 is set
    task automatic writeReg(input logic [31:0] data);
        if (data[11]) data[10:8] = 3'h0;
        xfer(8'h80, data);
    endtask : writeReg
endmodule : gcd_host_model

// ===== gcd_global_config_props.sv
// Checker on the ports of gcd_global_config.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module gcd_global_config_props (
    input wire logic                    clk,
    input wire logic                    reset,
    input wire gcd_pkg::gcd_access_type access,
    input wire logic                    stepDirModeSelectPin,
    input wire gcd_pkg::gcd_event_type  driverEvents,
    input wire gcd_pkg::gcd_motion_type motion,
    input wire logic [31:0]             readData_q,
    input wire logic                    readValid_q,
    input wire logic                    currentRefAnalog_q,
    input wire logic                    internalSense_q,
    input wire logic                    quietPwmEnable_q,
    input wire logic                    encoderCommutation_q,
    input wire logic                    motorDirection_q,
    input wire logic                    firstDiagPinN_q,
    input wire logic                    secondDiagPinN_q
);
    // Shadow of the stored word
    logic [16:0] cfgQ;
    wire gcd_pkg::gcd_event_type ev = driverEvents;
    wire wr = access.valid && access.addr == 8'h80;
    wire firstEvt = cfgQ[5] & (ev.overTemperature | ev.shortToGround
        | ev.chargePumpUndervoltage) | cfgQ[6] & ev.overTempPrewarning | cfgQ[7] & ev.motorStall;
    wire secondEvt = cfgQ[8] & ev.motorStall | cfgQ[9] & ev.tableIndexZero
        | cfgQ[10] & ev.chopperOnSecondHalf;
    always_ff @(posedge clk) begin
        if (reset) cfgQ <= 17'h0_0000;
        else if (wr) cfgQ <= access.wdata[16:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    reset_pin_a: assert property (disable iff (1'b0) reset |=> !firstDiagPinN_q)
        else $error("first pin not asserted in reset");
    static_bits_a: assert property (wr |=> ##1 {encoderCommutation_q, quietPwmEnable_q,
        internalSense_q, currentRefAnalog_q} == $past(access.wdata[3:0], 2))
        else $error("static outputs differ from written bits");
    direction_a: assert property (!$past(reset) |-> motorDirection_q ==
        ($past(motion.commandedDirection) ^ $past(cfgQ[4]))) else $error("direction wrong");
    first_ctrl_a: assert property ($past(stepDirModeSelectPin && !reset) |->
        firstDiagPinN_q == !$past(firstEvt)) else $error("first pin wrong");
    second_ctrl_a: assert property ($past(stepDirModeSelectPin && !cfgQ[11] && !reset) |->
        secondDiagPinN_q == !$past(secondEvt)) else $error("second pin wrong");
    int_out_a: assert property ($past(!stepDirModeSelectPin && !cfgQ[7] && !reset) |->
        firstDiagPinN_q == !$past(motion.interruptLevel)) else $error("interrupt pin wrong");
    poscomp_a: assert property ($past(!stepDirModeSelectPin && !cfgQ[8] && !reset) |->
        secondDiagPinN_q == !$past(motion.positionCompare)) else $error("compare pin wrong");
    dir_out_a: assert property ($past(!stepDirModeSelectPin && cfgQ[8] && !reset) |->
        secondDiagPinN_q == $past(motorDirection_q)) else $error("direction pin wrong");
    read_back_a: assert property (access.valid && access.addr == 8'h00 |=> readValid_q &&
        readData_q == {15'h0000, $past(cfgQ)}) else $error("read data wrong");
    write_quiet_a: assert property (access.valid && access.addr[7] |=> !readValid_q)
        else $error("write answered as read");
endmodule : gcd_global_config_props

bind gcd_global_config gcd_global_config_props u_gcd_global_config_props (.clk, .reset, .access,
    .stepDirModeSelectPin, .driverEvents, .motion, .readData_q, .readValid_q, .currentRefAnalog_q,
    .internalSense_q, .quietPwmEnable_q, .encoderCommutation_q, .motorDirection_q,
    .firstDiagPinN_q, .secondDiagPinN_q);

// ===== gcd_global_config_tb.sv
// Testbench for gcd_global_config driven by the host model.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
module gcd_global_config_tb;
    logic clk, reset, mode, pOld;
    gcd_pkg::gcd_access_type access;
    gcd_pkg::gcd_event_type ev;
    gcd_pkg::gcd_motion_type mo;
    logic [31:0] rd;
    logic rv, cur, isn, qp, enc, dir, p1, p2;
    logic [16:0] cfg;
    logic [31:0] expQ[$];
    int error_cnt = 0;
    int n_tests = 0;
    gcd_host_model u_gcd_host_model (.clk(clk), .access(access));
    gcd_global_config u_gcd_global_config (.clk(clk), .reset(reset), .access(access),
        .stepDirModeSelectPin(mode), .driverEvents(ev), .motion(mo), .readData_q(rd),
        .readValid_q(rv), .currentRefAnalog_q(cur), .internalSense_q(isn), .quietPwmEnable_q(qp),
        .encoderCommutation_q(enc), .motorDirection_q(dir), .firstDiagPinN_q(p1),
        .secondDiagPinN_q(p2));

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        u_gcd_host_model.xfer(a, 32'h0000_0000);
    endtask : rdChk
    task automatic wrCfg(input logic [16:0] c);
        u_gcd_host_model.writeReg(32'(c));
    endtask : wrCfg
    function automatic logic [1:0] pinExp(input logic [16:0] c, input logic m);
        if (m) return {!(c[5] & (ev.overTemperature | ev.shortToGround | ev.chargePumpUndervoltage)
            | c[6] & ev.overTempPrewarning | c[7] & ev.motorStall), !(c[8] & ev.motorStall
            | c[9] & ev.tableIndexZero | c[10] & ev.chopperOnSecondHalf)};
        return {!mo.interruptLevel, !mo.positionCompare};
    endfunction : pinExp
    task automatic conclude();
        chk("pending reads", 32'h0000_0000, 32'(expQ.size()));
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    // Read answers compared in order of issue
    always @(negedge clk) begin
        if (rv === 1'b1) chk("read", expQ.pop_front(), rd);
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run is under 1000 cycles
    initial begin
        #200_000;
        error_cnt++;
        conclude();
    end
    initial begin
        reset = 1'b1;
        mode = 1'b1;
        ev = '0;
        mo = '0;
        void'($urandom(3));
        repeat (20) @(negedge clk);
        chk("pin1 reset", 32'h0000_0000, 32'(p1));
        reset = 1'b0;
        rdChk(8'h00, 32'h0000_0000);
        for (int i = 0; i < 24; i++) begin
            cfg = 17'($urandom()) & 17'h1_F7FF;
            mode = 1'($urandom_range(1));
            if (!mode) cfg[8:7] = 2'b00;
            wrCfg(cfg);
            ev = 8'($urandom()) & 8'hFE;
            mo = 4'($urandom()) & 4'hD;
            repeat (3) @(negedge clk);
            chk("pins", 32'(pinExp(cfg, mode)), 32'({p1, p2}));
            chk("dir", 32'(mo.commandedDirection ^ cfg[4]), 32'(dir));
            chk("static", 32'(cfg[3:0]), 32'({enc, qp, isn, cur}));
            rdChk(8'h00, 32'(cfg));
        end
        u_gcd_host_model.xfer(8'h81, 32'hFFFF_FFFF);
        rdChk(8'h00, 32'(cfg));
        rdChk(8'h01, 32'h0000_0000);
        mode = 1'b1;
        wrCfg(17'h0_0800);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk) ev.lostStepIncrement = 1'b1;
            @(negedge clk) ev.lostStepIncrement = 1'b0;
            repeat (3) @(negedge clk);
            chk("skip", 32'(i[0]), 32'(p2));
        end
        mode = 1'b0;
        mo = '0;
        wrCfg(17'h0_0180);
        mo.commandedDirection = 1'b1;
        repeat (4) @(negedge clk);
        chk("dirpin", 32'h0000_0001, 32'(p2));
        pOld = p1;
        mo.stepPulse = 1'b1;
        @(negedge clk) mo.stepPulse = 1'b0;
        repeat (3) @(negedge clk);
        chk("step", 32'(!pOld), 32'(p1));
        conclude();
    end
endmodule : gcd_global_config_tb
